/* rtl/cuts_consts.svh */
// Constants for the capture unit and timer select block.
// Assumes inclusion by the design file; rtl/cuts_pkg.sv does not include it.
`ifndef CUTS_CONSTS_SVH
`define CUTS_CONSTS_SVH
// Register offsets on the plain register port.
`define CUTS_A_SEL_A     4'h0
`define CUTS_A_SEL_B     4'h1
`define CUTS_A_ODC       4'h2
`define CUTS_A_FLAG      4'h3
`define CUTS_A_ENB       4'h4
`define CUTS_A_CFG       4'h5
`define CUTS_A_CTL0      4'h6
`define CUTS_A_CAPL0     4'h7
// Writable bit masks of the select registers.
`define CUTS_SEL_A_MASK  8'hD7
`define CUTS_SEL_B_MASK  8'h17
`define CUTS_SEL_B_SMALL 8'h03
`define CUTS_ODC_MASK    8'hFC
`define CUTS_ODC_LSB     2
`define CUTS_ROUTE_BIT   1
// Mode codes.
`define CUTS_M_OFF       4'h0
`define CUTS_M_FALL      4'h4
`define CUTS_M_RISE      4'h5
`define CUTS_M_RISE4     4'h6
`define CUTS_M_RISE16    4'h7
`define CUTS_CFG_RESET   8'h02
`define CUTS_FLAG_BIT0   1
`define CUTS_PRE4_LAST   4'h3
`define CUTS_PRE16_LAST  4'hF
`endif

/* rtl/cuts_pkg.sv */
// Types shared by the capture unit and timer select block.
// Assumes the constants header is on the include path.
package cuts_pkg;
    typedef struct packed {
        logic [15:0] ccTimer;
        logic [1:0]  pwTimerIdx;
    } cuts_base_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } cuts_bus_t;
endpackage

/* rtl/cuts_capture_unit.sv */
// Capture channels four to ten with the shared timer select logic.
// Assumes timers and pins synchronous to clk_sys; compare and PWM are
// handled elsewhere, this block only supplies their time-base choices.
`timescale 1ns/100ps
`default_nettype none
`include "cuts_consts.svh"
// Function
// - Capture/compare uses only timers one/three/five/seven.
// - Pulse width uses only timers two/four/six/eight.
// - All channels run together, sharing timers.
// - Register a: channels 4-7, b: 8-10.
// - Channel four and five time-base codes.
// - Channel six and seven time-base codes.
// - Full variant channel eight code table.
// - Reduced variant channel eight: timer one.
// - Channels nine, ten codes; absent when reduced.
// - Open-drain bits seven to two drive pins.
// - Route bit selects port E or H.
// - Capture copies full 16-bit timer value.
// - Falling, rising, 4th or 16th rising edge.
// - Capture sets flag; only software clears.
// - New capture overwrites old, no overflow.
// - Port write on channel four output pin captures.
// - Prescaler cleared when off or not capture.
// - Prescaler change keeps count, may capture.
// - Codes 0100-0111 select the capture kinds.
// - Code 0000 disables channel, clears its prescaler.
module cuts_capture_unit
    import cuts_pkg::*;
#(
    parameter int NCH = 7,
    parameter bit SMALL_MEM = 1'b0
) (
    // Clock and reset.
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // Register port.
    input  wire logic [3:0]        regAddr,
    input  wire logic [7:0]        regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [7:0]             regRdata,
    // Extended channel register port: control, capture low, high.
    input  wire logic [4:0]        chAddr,
    input  wire logic              chWr,
    input  wire logic              chRd,
    output logic [7:0]             chRdata,
    // Timers one to eight, index 0 is timer one.
    input  wire logic [7:0][15:0]  timerCount,
    // Pins: port E and port H copies for channels six to nine.
    input  wire logic [NCH-1:0]    pinEIn,
    input  wire logic [3:0]        pinHIn,
    input  wire logic [NCH-1:0]    pinDirIn,
    input  wire logic [NCH-1:0]    portWrite,
    input  wire logic [NCH-1:0]    pinOutVal,
    output logic [NCH-1:0]         pinEOut,
    output logic [NCH-1:0]         pinEOe,
    output logic [3:0]             pinHOut,
    output logic [3:0]             pinHOe,
    // Time bases for the compare and PWM parts.
    output cuts_base_t [NCH-1:0]   chanBase,
    output logic [NCH-1:0]         captureFlag
);
    // ==========================================================
    // Registers
    // Shared port: select, open-drain,
    // enable and route registers. Channel
    // port: per-channel control and capture
    // bytes, addressed by channel index.
    // Missing select bits are masked on write
    // so they read back as zero.
    logic [7:0]         timerSelA;
    logic [7:0]         timerSelB;
    logic [7:0]         openDrainCtl;
    logic [7:0]         irqEnable;
    logic [7:0]         cfgWordHigh;
    logic [NCH-1:0]     flagReg;
    logic [NCH-1:0][3:0]  modeField;
    logic [NCH-1:0][15:0] capValue;
    logic [7:0]         next_regRdata;
    logic [7:0]         next_chRdata;

    // Channels nine and ten are absent on the
    // reduced variant: their bits stay zero.
    wire logic [7:0] selBMask = SMALL_MEM ? `CUTS_SEL_B_SMALL
                                          : `CUTS_SEL_B_MASK;
    // One keeps channels six to nine on port E.
    wire logic pinRouteSelect = cfgWordHigh[`CUTS_ROUTE_BIT];
    wire logic [1:0] chSub = chAddr[1:0];
    wire logic [2:0] chIdx = chAddr[4:2];
    wire logic chValid = (chIdx < 3'(NCH)) && (chSub != 2'b11);

    // ==========================================================
    // Register write path
    // Writes land at the strobe's edge.
    // The reserved select code is stored as
    // written and decoded as code zero, since
    // timers one and two exist everywhere.
    // Shared register writes: select, open-drain, enable and route.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            timerSelA    <= 8'h00;
            timerSelB    <= 8'h00;
            openDrainCtl <= 8'h00;
            irqEnable    <= 8'h00;
            cfgWordHigh  <= `CUTS_CFG_RESET;
        end else if (regWr) begin
            unique case (regAddr)
                `CUTS_A_SEL_A: timerSelA <= regWdata & `CUTS_SEL_A_MASK;
                `CUTS_A_SEL_B: timerSelB <= regWdata & selBMask;
                `CUTS_A_ODC:   openDrainCtl <= regWdata & `CUTS_ODC_MASK;
                `CUTS_A_ENB:   irqEnable <= regWdata;
                `CUTS_A_CFG:   cfgWordHigh <= regWdata;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Register read path
    // Data follow one cycle after the strobe.
    // Unmapped offsets and channel slots read
    // as zero rather than a neighbour's value.
    always_comb begin
        next_regRdata = 8'h00;
        unique case (regAddr)
            `CUTS_A_SEL_A: next_regRdata = timerSelA;
            `CUTS_A_SEL_B: next_regRdata = timerSelB;
            `CUTS_A_ODC:   next_regRdata = openDrainCtl;
            `CUTS_A_FLAG:  next_regRdata = 8'({flagReg, 1'b0});
            `CUTS_A_ENB:   next_regRdata = irqEnable;
            `CUTS_A_CFG:   next_regRdata = cfgWordHigh;
            default:       next_regRdata = 8'h00;
        endcase
        next_chRdata = 8'h00;
        if (chValid) begin
            unique case (chSub)
                2'b00:   next_chRdata = {4'h0, modeField[chIdx]};
                2'b01:   next_chRdata = capValue[chIdx][7:0];
                default: next_chRdata = capValue[chIdx][15:8];
            endcase
        end
    end

    // Zero between reads keeps the bus quiet.
    // A stray read is then easy to spot.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 8'h00;
            chRdata  <= 8'h00;
        end else begin
            regRdata <= regRd ? next_regRdata : 8'h00;
            chRdata  <= chRd ? next_chRdata : 8'h00;
        end
    end

    // ==========================================================
    // Time-base selection, per channel
    // Entries are two octal digits. The first
    // is the capture timer index, always even,
    // so an odd-numbered timer. The upper two
    // bits of the second pick an even-numbered
    // PWM timer; its low bit is unused.
    // Only odd timers feed capture, only even feed PWM.
    function automatic logic [5:0] baseCode(input int ch,
                                           input logic [7:0] sa,
                                           input logic [7:0] sb);
        // Returns capture timer index in [5:3], PWM index in [2:1].
        logic [5:0] r;
        r = 6'o01;
        unique case (ch)
            0: r = (sa[1:0] == 2'b01) ? 6'o23 :
                   (sa[1:0] == 2'b10) ? 6'o25 : 6'o01;
            1: r = sa[2] ? 6'o43 : 6'o01;
            2: r = sa[4] ? 6'o41 : 6'o01;
            3: r = (sa[7:6] == 2'b01) ? 6'o43 :
                   (sa[7:6] == 2'b10) ? 6'o45 :
                   (sa[7:6] == 2'b11) ? 6'o47 : 6'o01;
            // Channel eight differs on the small variant.
            4: r = (sb[1:0] == 2'b01) ? (SMALL_MEM ? 6'o03 : 6'o63) :
                   (sb[1:0] == 2'b10) ? (SMALL_MEM ? 6'o05 : 6'o65) :
                   6'o01;
            5: r = sb[2] ? 6'o63 : 6'o01;
            6: r = sb[4] ? 6'o61 : 6'o01;
            default: r = 6'o01;
        endcase
        return r;
    endfunction

    // ==========================================================
    // Capture channels
    // Channels only read the timer buses, so
    // they share timers without arbitration,
    // at the cost of one mux per channel.
    // Every channel has its own logic; timers are only read.
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gChan
            logic [5:0]  code;
            logic [15:0] ccTime;
            logic        pinRaw;
            logic        syncA;
            logic        syncB;
            logic        syncPrev;
            logic [3:0]  preCount;
            logic        isCapture;
            logic        present;
            logic        rise;
            logic        fall;
            logic        trig;
            logic        preHit;
            logic        ctlWr;
            logic        flagClr;

            assign code   = baseCode(g, timerSelA, timerSelB);
            assign ccTime = timerCount[code[5:3]];
            assign chanBase[g] = '{ccTimer: ccTime,
                                   pwTimerIdx: code[2:1]};
            // Channels nine and ten do not exist when reduced.
            assign present = !(SMALL_MEM && g >= 5);
            // The unselected port is ignored.
            // Its edges never reach the sync.
            // Route channels six to nine to port E or H.
            if (g >= 2 && g <= 5) begin : gRoute
                assign pinRaw = pinRouteSelect ? pinEIn[g]
                                               : pinHIn[g-2];
            end else begin : gFixed
                assign pinRaw = pinEIn[g];
            end
            assign isCapture = present &&
                               (modeField[g][3:2] == 2'b01);
            assign rise = syncB & ~syncPrev;
            assign fall = ~syncB & syncPrev;
            // Only rising edges count. The edge
            // that finds the counter at its last
            // value captures; the 4:1 setting
            // reads the low two bits and wraps.
            // Event kind from the mode field.
            assign preHit =
                (modeField[g] == `CUTS_M_RISE4)
                    ? (preCount[1:0] == `CUTS_PRE4_LAST) :
                (modeField[g] == `CUTS_M_RISE16)
                    ? (preCount == `CUTS_PRE16_LAST) : 1'b1;
            // A port write skips the prescaler:
            // it is a software trigger.
            // A port write on channel four's output pin captures.
            assign trig = isCapture && (
                (modeField[g] == `CUTS_M_FALL) ? fall :
                rise && preHit) ||
                (isCapture && g == 0 && !pinDirIn[g] && portWrite[g]);
            assign ctlWr = chWr && chIdx == 3'(g) && chSub == 2'b00;
            assign flagClr = regWr && regAddr == `CUTS_A_FLAG &&
                             !regWdata[g + `CUTS_FLAG_BIT0];

            // Only the second stage feeds the
            // detector. All stages reset low,
            // like the idle pin, so no false edge
            // follows reset; capture lags 3 clocks.
            // Two-stage synchroniser, then edge detection.
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    syncA    <= 1'b0;
                    syncB    <= 1'b0;
                    syncPrev <= 1'b0;
                end else begin
                    syncA    <= pinRaw;
                    syncB    <= syncA;
                    syncPrev <= syncB;
                end
            end

            // A direct move between prescaler
            // settings keeps the count, so the
            // first capture may come early. Off
            // first clears it within one clock.
            // Cleared only outside capture modes.
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    preCount <= 4'h0;
                end else if (!isCapture) begin
                    preCount <= 4'h0;
                end else if (rise) begin
                    preCount <= preCount + 4'h1;
                end
            end

            // Writes to an absent channel are
            // dropped, so it stays off.
            // Code zero stops the channel and clears its prescaler; capture and flag are kept.
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    modeField[g] <= `CUTS_M_OFF;
                end else if (ctlWr && present) begin
                    modeField[g] <= regWdata[3:0];
                end
            end

            // A capture beats a byte write in the
            // same cycle; a lost timer value is
            // worse than a lost preset.
            // Full 16-bit copy, older value overwritten.
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    capValue[g] <= 16'h0000;
                end else if (trig) begin
                    capValue[g] <= ccTime;
                end else if (chWr && chIdx == 3'(g) && present &&
                             chSub != 2'b00 && chSub != 2'b11) begin
                    if (chSub == 2'b01)
                        capValue[g][7:0] <= regWdata;
                    else
                        capValue[g][15:8] <= regWdata;
                end
            end

            // Only a written zero clears a flag.
            // Writing ones leaves others alone.
            // Set wins over a software clear.
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    flagReg[g] <= 1'b0;
                end else if (trig) begin
                    flagReg[g] <= 1'b1;
                end else if (flagClr) begin
                    flagReg[g] <= 1'b0;
                end
            end

            // Open drain releases instead of
            // driving high; a pull-up outside
            // makes the level.
            // Open-drain drives only low when the bit is set.
            logic outMode;
            logic odSel;
            logic drvOe;
            assign outMode = present && !isCapture &&
                             modeField[g] != `CUTS_M_OFF &&
                             !pinDirIn[g];
            // Channel ten has no open-drain bit.
            if (g + `CUTS_ODC_LSB < $bits(openDrainCtl)) begin : gOd
                assign odSel = openDrainCtl[g + `CUTS_ODC_LSB];
            end else begin : gNoOd
                assign odSel = 1'b0;
            end
            assign drvOe = outMode && (!odSel || !pinOutVal[g]);
            if (g >= 2 && g <= 5) begin : gOutR
                assign pinEOut[g]   = pinOutVal[g];
                assign pinEOe[g]    = drvOe && pinRouteSelect;
                assign pinHOut[g-2] = pinOutVal[g];
                assign pinHOe[g-2]  = drvOe && !pinRouteSelect;
            end else begin : gOutF
                assign pinEOut[g] = pinOutVal[g];
                assign pinEOe[g]  = drvOe;
            end
        end
    endgenerate

    // ==========================================================
    // Flag outputs
    // Gating by the enable register is left
    // to the interrupt controller outside.
    assign captureFlag = flagReg;
endmodule
`default_nettype wire

/* dv/cuts_capture_unit_asserts.sv */
// Checker for the capture unit, bound onto its top module.
// Assumes the register offsets and reset values of the design.
`timescale 1ns/100ps
`default_nettype none
module cuts_capture_unit_chk
    import cuts_pkg::*;
#(
    parameter int NCH = 7,
    parameter bit SMALL_MEM = 1'b0
) (
    // Clock, reset and register port.
    input wire logic                 clk_sys,
    input wire logic                 rstn,
    input wire logic [3:0]           regAddr,
    input wire logic [7:0]           regWdata,
    input wire logic                 regWr,
    input wire logic                 regRd,
    input wire logic [7:0]           regRdata,
    input wire logic                 chRd,
    input wire logic [7:0]           chRdata,
    // Timers, pins and time bases.
    input wire logic [7:0][15:0]     timerCount,
    input wire logic [NCH-1:0]       pinEOe,
    input wire logic [3:0]           pinHOe,
    input wire cuts_base_t [NCH-1:0] chanBase,
    input wire logic [NCH-1:0]       captureFlag
);
    // ==========================================================
    // Shadow copies of the select and route registers.
    logic [7:0] selA;
    logic [7:0] selB;
    logic       route;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            selA <= 8'h00;
            selB <= 8'h00;
            route <= 1'b1;
        end else if (regWr) begin
            if (regAddr == 4'h0) selA <= regWdata;
            if (regAddr == 4'h1) selB <= regWdata;
            if (regAddr == 4'h5) route <= regWdata[1];
        end
    end
    // The reserved code behaves as code zero, so it is folded here.
    wire [1:0] c4 = (selA[1:0] == 2'b11) ? 2'b00 : selA[1:0];
    wire [1:0] c7 = selA[7:6];
    wire [1:0] c8 = (selB[1:0] == 2'b11) ? 2'b00 : selB[1:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // Assertions.
    a_ch4_base: assert property (
        chanBase[0] == {timerCount[c4 == 0 ? 0 : 2], c4})
        else $error("channel four time base wrong");
    a_ch5_base: assert property (
        chanBase[1] == {timerCount[selA[2] ? 4 : 0], 1'b0, selA[2]})
        else $error("channel five time base wrong");
    a_ch6_base: assert property (
        chanBase[2] == {timerCount[selA[4] ? 4 : 0], 2'b00})
        else $error("channel six time base wrong");
    a_ch7_base: assert property (
        chanBase[3] == {timerCount[c7 == 0 ? 0 : 4], c7})
        else $error("channel seven time base wrong");
    a_ch8_base: assert property (
        chanBase[4] == {timerCount[(c8 == 0 || SMALL_MEM) ? 0 : 6], c8})
        else $error("channel eight time base wrong");
    a_flag_sticky: assert property (
        !(regWr && regAddr == 4'h3) |=> ($past(captureFlag) & ~captureFlag) == '0)
        else $error("capture flag fell without a clear");
    a_rdata_idle: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data without a read");
    a_chdata_idle: assert property (!chRd |=> chRdata == 8'h00)
        else $error("channel data without a read");
    a_route_idle: assert property (
        (route ? pinHOe : pinEOe[5:2]) == 4'h0)
        else $error("unrouted port drives a pin");
    c_flag: cover property ($rose(captureFlag[0]));
    c_route: cover property (!route && $rose(captureFlag[2]));
    c_read: cover property (chRd ##1 chRdata != 8'h00);
endmodule
bind cuts_capture_unit cuts_capture_unit_chk #(
    .NCH(NCH), .SMALL_MEM(SMALL_MEM)
) u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .chRd(chRd), .chRdata(chRdata),
    .timerCount(timerCount), .pinEOe(pinEOe), .pinHOe(pinHOe),
    .chanBase(chanBase), .captureFlag(captureFlag)
);
`default_nettype wire

/* dv/cuts_pin_src.sv */
// Model of the external sources on the capture pins.
// Assumes one-cycle toggle requests from the bench.
`timescale 1ns/100ps
`default_nettype none
module cuts_pin_src (
    // Clock, reset and requests.
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [10:0] tgl,
    // Pin levels, port E in 6:0 and port H in 10:7.
    output logic      [10:0] lvl
);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lvl <= 11'h000;
        end else begin
            lvl <= lvl ^ tgl;
        end
    end
endmodule
`default_nettype wire

/* dv/cuts_capture_unit_bench.sv */
// Bench for the capture unit: registers, captures, prescale, routing.
// Assumes the pin source model and the checker compile first.
`timescale 1ns/100ps
`default_nettype none
module cuts_capture_unit_bench import cuts_pkg::*;;
    logic             clk_sys = 1'b0;
    logic             rstn = 1'b0;
    logic [3:0]       regAddr = 4'h0;
    logic [7:0]       regWdata = 8'h00;
    logic             regWr = 1'b0;
    logic             regRd = 1'b0;
    logic [4:0]       chAddr = 5'h00;
    logic             chWr = 1'b0;
    logic             chRd = 1'b0;
    logic [7:0][15:0] tmr = 128'h8F80_7E70_6D60_5C50_4B40_3A30_2920_1810;
    logic [6:0]       pinDir = 7'h7F;
    logic [6:0]       portWr = 7'h00;
    logic [10:0]      tgl = 11'h000;
    logic [6:0]       pinOut = 7'h00;
    wire  [10:0]      lvl;
    wire  [6:0]       eOut;
    wire  [6:0]       eOe;
    wire  [3:0]       hOut;
    wire  [3:0]       hOe;
    logic [7:0]       regRdata;
    logic [7:0]       chRdata;
    cuts_base_t [6:0] chanBase;
    logic [6:0]       flag;
    int               bad_count = 0;
    int               check_count = 0;
    int               cyc = 0;
    cuts_capture_unit #(.NCH(7), .SMALL_MEM(1'b0)) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .chAddr(chAddr), .chWr(chWr), .chRd(chRd),
        .chRdata(chRdata), .timerCount(tmr), .pinEIn(lvl[6:0]),
        .pinHIn(lvl[10:7]), .pinDirIn(pinDir), .portWrite(portWr),
        .pinOutVal(pinOut), .pinEOut(eOut), .pinEOe(eOe), .pinHOut(hOut),
        .pinHOe(hOe),
        .chanBase(chanBase), .captureFlag(flag));
    cuts_pin_src u_src (.clk_sys(clk_sys), .rstn(rstn), .tgl(tgl), .lvl(lvl));
    // ==========================================================
    // Clock, timeout and shared tasks.
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp,
                       input string m);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input bit ch, input logic [4:0] a, input logic [7:0] d);
        regWdata <= d;
        chAddr <= a;
        regAddr <= a[3:0];
        chWr <= ch;
        regWr <= !ch;
        @(posedge clk_sys);
        chWr <= 1'b0;
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input bit ch, input logic [4:0] a, input logic [7:0] e);
        chAddr <= a;
        regAddr <= a[3:0];
        chRd <= ch;
        regRd <= !ch;
        @(posedge clk_sys);
        chRd <= 1'b0;
        regRd <= 1'b0;
        #1 chk(ch ? chRdata : regRdata, e, "read");
        @(posedge clk_sys);
    endtask
    task automatic tog(input int i);
        tgl <= 11'h001 << i;
        @(posedge clk_sys);
        tgl <= 11'h000;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic rises(input int i, input int n);
        repeat (2 * n) tog(i);
    endtask
    // Mode change then flag clear keeps stale events out of the result.
    task automatic setMode(input logic [4:0] a, input logic [7:0] m);
        wr(1, a, 8'h00);
        wr(1, a, m);
        wr(0, 5'h03, 8'h00);
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_regs();
        rd(0, 5'h00, 8'h00);
        rd(0, 5'h05, 8'h02);
        rd(0, 5'h0F, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(0, 5'h00, {c[1:0], 6'h16});
            chk(chanBase[3], {tmr[c == 0 ? 0 : 4], c[1:0]}, "ch7");
        end
        rd(0, 5'h00, 8'hD6);
        chk(chanBase[0], {tmr[2], 2'b10}, "ch4");
        chk(chanBase[1], {tmr[4], 2'b01}, "ch5");
        chk(chanBase[2], {tmr[4], 2'b00}, "ch6");
        wr(0, 5'h01, 8'hFE);
        rd(0, 5'h01, 8'h16);
        chk(chanBase[4], {tmr[6], 2'b10}, "ch8");
        chk(chanBase[5], {tmr[6], 2'b01}, "ch9");
        chk(chanBase[6], {tmr[6], 2'b00}, "ch10");
        wr(0, 5'h00, 8'h00);
        wr(0, 5'h01, 8'h00);
        $display("end t_regs");
    endtask
    task automatic t_capture();
        setMode(5'h00, 8'h05);
        rises(0, 1);
        chk(flag[0], 1'b1, "flag");
        rd(0, 5'h03, 8'h02);
        rd(1, 5'h01, 8'h10);
        rd(1, 5'h02, 8'h18);
        tmr[0] <= 16'hABCD;
        rises(0, 1);
        rd(1, 5'h01, 8'hCD);
        rd(1, 5'h02, 8'hAB);
        wr(0, 5'h03, 8'hFF);
        chk(flag[0], 1'b1, "flag kept");
        wr(0, 5'h03, 8'hFD);
        chk(flag[0], 1'b0, "flag clear");
        $display("end t_capture");
    endtask
    task automatic t_prescale();
        for (int k = 0; k < 2; k++) begin
            setMode(5'h00, k ? 8'h07 : 8'h06);
            rises(0, k ? 15 : 3);
            chk(flag[0], 1'b0, "early");
            rises(0, 1);
            chk(flag[0], 1'b1, "nth");
        end
        setMode(5'h00, 8'h04);
        tog(0);
        chk(flag[0], 1'b0, "rise");
        tog(0);
        chk(flag[0], 1'b1, "fall");
        setMode(5'h00, 8'h06);
        rises(0, 2);
        setMode(5'h00, 8'h06);
        rises(0, 3);
        chk(flag[0], 1'b0, "cleared");
        rises(0, 1);
        chk(flag[0], 1'b1, "restart");
        rises(0, 1);
        wr(1, 5'h00, 8'h07);
        wr(0, 5'h03, 8'h00);
        rises(0, 10);
        chk(flag[0], 1'b0, "kept count");
        rises(0, 1);
        chk(flag[0], 1'b1, "partial count");
        $display("end t_prescale");
    endtask
    task automatic t_portwr();
        setMode(5'h00, 8'h05);
        pinDir[0] <= 1'b0;
        portWr[0] <= 1'b1;
        @(posedge clk_sys);
        portWr[0] <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(flag[0], 1'b1, "port write");
        pinDir[0] <= 1'b1;
        $display("end t_portwr");
    endtask
    task automatic t_route();
        wr(0, 5'h05, 8'h00);
        setMode(5'h08, 8'h05);
        rises(2, 1);
        chk(flag[2], 1'b0, "port E");
        rises(7, 1);
        chk(flag[2], 1'b1, "port H");
        wr(0, 5'h05, 8'h02);
        $display("end t_route");
    endtask
    task automatic t_odrain();
        pinDir <= 7'h7A;
        pinOut <= 7'h05;
        setMode(5'h00, 8'h08);
        setMode(5'h08, 8'h08);
        chk({hOut, eOut}, {4'h1, 7'h05}, "pin out");
        chk({hOe, eOe}, {4'h0, 7'h05}, "push-pull");
        wr(0, 5'h02, 8'h04);
        chk({hOe, eOe}, {4'h0, 7'h04}, "od high");
        pinOut <= 7'h04;
        @(posedge clk_sys);
        chk({hOe, eOe}, {4'h0, 7'h05}, "od low");
        wr(0, 5'h05, 8'h00);
        chk({hOe, eOe}, {4'h1, 7'h01}, "port H out");
        wr(0, 5'h05, 8'h02);
        setMode(5'h00, 8'h00);
        setMode(5'h08, 8'h00);
        wr(0, 5'h02, 8'h00);
        pinDir <= 7'h7F;
        pinOut <= 7'h00;
        $display("end t_odrain");
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_capture();
        t_prescale();
        t_portwr();
        t_route();
        t_odrain();
        summarize();
    end
endmodule
`default_nettype wire
